// ### hw/etd_pkg.sv
// Purpose: shared constants for the transmit descriptor status logic
// Assumes: one 40 MHz clock, word 0 and word 1 bit layout as below
// Notes:   offsets are byte addresses on the plain register port
package etd_pkg;
	// word 0 status and control bit positions
	localparam int W0_DEFERRED       = 0;
	localparam int W0_UNDERFLOW      = 1;
	localparam int W0_EXCESS_DEFER   = 2;
	localparam int W0_EXCESS_COLL    = 8;
	localparam int W0_LATE_COLL      = 9;
	localparam int W0_NO_CARRIER     = 10;
	localparam int W0_CARRIER_LOST   = 11;
	localparam int W0_PAYLOAD_FAULT  = 12;
	localparam int W0_FLUSH_DROPPED  = 13;
	localparam int W0_JABBER_EXPIRED = 14;
	localparam int W0_COMBINED_FAULT = 15;
	localparam int W0_IP_HDR_FAULT   = 16;
	localparam int W0_CHAINED_NEXT   = 20;
	localparam int W0_FIRST_SEGMENT  = 28;
	// word 1 field positions
	localparam int W1_ADDR_SELECT    = 31;
	localparam int W1_ACTION_HI      = 30;
	localparam int W1_ACTION_LO      = 29;
	localparam int W1_LEN_HI         = 12;
	// source address action codes
	localparam logic [1:0] SA_KEEP    = 2'h0;
	localparam logic [1:0] SA_INSERT  = 2'h1;
	localparam logic [1:0] SA_REPLACE = 2'h2;
	// header check figures
	localparam logic [15:0] ETYPE_IPV4     = 16'h0800;
	localparam logic [15:0] ETYPE_IPV6     = 16'h86DD;
	localparam logic [3:0]  VER_IPV4       = 4'h4;
	localparam logic [3:0]  VER_IPV6       = 4'h6;
	localparam logic [3:0]  IHL_MIN        = 4'h5;
	localparam logic [7:0]  IPV6_HDR_BYTES = 8'h28;
	// register map
	localparam logic [7:0]  REG_CTRL      = 8'h00;
	localparam logic [7:0]  REG_LAST_WB   = 8'h04;
	localparam logic [7:0]  REG_LIVE      = 8'h08;
	localparam logic [7:0]  REG_LAST_W1   = 8'h0C;
	localparam int          CTRL_JAB_DIS  = 0;
	localparam int          CTRL_HALF_DUP = 1;
	localparam logic [1:0]  CTRL_RESET    = 2'h0;
	// frame tracking
	typedef enum logic [0:0]
	{
		ETD_IDLE  = 1'b0,
		ETD_FRAME = 1'b1
	} etd_state_e;
endpackage

// ### hw/etd_link_if.sv
// Purpose: carrier between the top and its decode and check leaves
// Assumes: single clock domain, all signals combinational
// Notes:   top drives the inputs of both leaves
`timescale 1ns/1ps
`default_nettype none
interface etd_link_if;
	logic [31:0] word1;
	logic        dec_insert;
	logic        dec_replace;
	logic        dec_select;
	logic [12:0] dec_len;
	logic        dec_skip;
	logic        hv;
	logic [15:0] ethertype;
	logic [3:0]  ver;
	logic [3:0]  ihl;
	logic [7:0]  bytes;
	logic        hdr_fault;
	modport top (output word1, hv, ethertype, ver, ihl, bytes,
		input dec_insert, dec_replace, dec_select, dec_len, dec_skip,
		hdr_fault);
	modport dec (input word1,
		output dec_insert, dec_replace, dec_select, dec_len, dec_skip);
	modport hdr (input hv, ethertype, ver, ihl, bytes, output hdr_fault);
endinterface
`default_nettype wire

// ### hw/etd_word_one_decode.sv
// Purpose: decode descriptor word 1 fields
// Assumes: first segment gating is done by the caller
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
module etd_word_one_decode
	import etd_pkg::*;
(
	etd_link_if.dec lnk
);
	wire [1:0] action_code = lnk.word1[W1_ACTION_HI:W1_ACTION_LO];

	// reserved code 2'b11 matches neither term
	assign lnk.dec_insert  = (action_code == SA_INSERT);
	assign lnk.dec_replace = (action_code == SA_REPLACE);
	assign lnk.dec_select  = lnk.word1[W1_ADDR_SELECT];
	// bits 28:13 never looked at
	assign lnk.dec_len     = lnk.word1[W1_LEN_HI:0];
	assign lnk.dec_skip    = (lnk.word1[W1_LEN_HI:0] == 13'h0000);
endmodule // etd_word_one_decode
`default_nettype wire

// ### hw/etd_ip_header_check.sv
// Purpose: judge the IP header of a frame about to be sent
// Assumes: bytes is the count of header bytes the application supplied
// Notes:   non-IP frames never fault
`timescale 1ns/1ps
`default_nettype none
module etd_ip_header_check
	import etd_pkg::*;
(
	etd_link_if.hdr lnk
);
	wire       is_v4     = (lnk.ethertype == ETYPE_IPV4);
	wire       is_v6     = (lnk.ethertype == ETYPE_IPV6);
	wire [7:0] ihl_bytes = {2'h0, lnk.ihl, 2'h0};
	wire       v4_len    = is_v4 & (ihl_bytes != lnk.bytes);
	wire       v4_short  = is_v4 & (lnk.ihl < IHL_MIN);
	wire       v6_len    = is_v6 & (lnk.bytes != IPV6_HDR_BYTES);
	wire       ver_bad   = (is_v4 & (lnk.ver != VER_IPV4))
		| (is_v6 & (lnk.ver != VER_IPV6));

	assign lnk.hdr_fault = lnk.hv & (v4_len | v4_short | v6_len | ver_bad);
endmodule // etd_ip_header_check
`default_nettype wire

// ### hw/eth_tx_descriptor_status_ctrl.sv
// Purpose: transmit descriptor word 0 status and word 1 decode
// Assumes: all MAC and DMA inputs are on the same 40 MHz clock
// Notes:   only the status bits owned here are set in the written word
//
// Overview of operation
// - IPv4 header length versus supplied bytes
// - IPv6 main header must be 40 bytes
// - Length/Type must agree with IP version
// - IPv4 header length below five faults
// - bit 15 ORs the listed fault bits
// - jabber timeout sets bit 14 unless disabled
// - flush discard sets bit 13
// - carrier deferral sets bit 0, half duplex
// - word 1 bits 30:29 select address action
// - word 1 bit 31 picks address register
// - changed source address forces CRC recompute
// - address action only on first segment
// - buffer one length from word 1 12:0
// - zero buffer one length skips it
// - first segment bit gates per-frame controls
// - chained bit makes second address next pointer
`timescale 1ns/1ps
`default_nettype none
module eth_tx_descriptor_status_ctrl
	import etd_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic      [31:0] reg_rdata,
	input  wire logic        desc_valid,
	input  wire logic [31:0] desc_word0,
	input  wire logic [31:0] desc_word1,
	output logic      [12:0] buf1_length,
	output logic             buf1_skip,
	output logic             buf2_is_next_ptr,
	output logic             sa_insert,
	output logic             sa_replace,
	output logic             sa_addr_select,
	output logic             crc_recompute,
	input  wire logic        hdr_valid,
	input  wire logic [15:0] hdr_length_type,
	input  wire logic [3:0]  hdr_version,
	input  wire logic [3:0]  hdr_ihl,
	input  wire logic [7:0]  hdr_bytes,
	input  wire logic        jabber_event,
	input  wire logic        flush_event,
	input  wire logic        carrier_lost_event,
	input  wire logic        no_carrier_event,
	input  wire logic        late_coll_event,
	input  wire logic        excess_coll_event,
	input  wire logic        excess_defer_event,
	input  wire logic        underflow_event,
	input  wire logic        payload_fault_event,
	input  wire logic        defer_event,
	input  wire logic        frame_end,
	output logic             wb_valid,
	output logic      [31:0] wb_word0
);

	////////////////////////////////////////////////////////////////////
	// leaves

	etd_link_if lnk ();

	assign lnk.word1     = desc_word1;
	assign lnk.hv        = hdr_valid;
	assign lnk.ethertype = hdr_length_type;
	assign lnk.ver       = hdr_version;
	assign lnk.ihl       = hdr_ihl;
	assign lnk.bytes     = hdr_bytes;

	etd_word_one_decode u_decode
	(
		.lnk (lnk.dec)
	);

	etd_ip_header_check u_check
	(
		.lnk (lnk.hdr)
	);

	////////////////////////////////////////////////////////////////////
	// register port

	logic [1:0]  ctrl;
	logic [31:0] last_wb;
	logic [31:0] last_w1;

	wire jabber_disable_bit = ctrl[CTRL_JAB_DIS];
	wire half_duplex        = ctrl[CTRL_HALF_DUP];
	wire hit_ctrl           = (reg_addr == REG_CTRL);
	wire hit_last_wb        = (reg_addr == REG_LAST_WB);
	wire hit_live           = (reg_addr == REG_LIVE);
	wire hit_last_w1        = (reg_addr == REG_LAST_W1);

	logic [31:0] live_word;
	logic [31:0] read_mux;
	logic        frame_open;

	// unmapped addresses read as zero; control bit 2 shows an open
	// frame and is read-only, so software can spot a missing frame end
	assign read_mux = hit_ctrl ? {29'h0000_0000, frame_open, ctrl}
		: hit_last_wb ? last_wb
		: hit_live ? live_word
		: hit_last_w1 ? last_w1
		: 32'h0000_0000;

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			ctrl <= CTRL_RESET;
		else if (reg_write && hit_ctrl)
			ctrl <= reg_wdata[1:0];
	end

	// data stands only in the cycle after the read strobe
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			reg_rdata <= 32'h0000_0000;
		else if (reg_read)
			reg_rdata <= read_mux;
		else
			reg_rdata <= 32'h0000_0000;
	end

	////////////////////////////////////////////////////////////////////
	// descriptor decode

	wire first_seg  = desc_word0[W0_FIRST_SEGMENT];
	wire chained    = desc_word0[W0_CHAINED_NEXT];
	wire take_desc  = desc_valid;
	wire take_first = desc_valid & first_seg;

	// buffer fields apply to every descriptor
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			buf1_length      <= 13'h0000;
			buf1_skip        <= 1'b0;
			buf2_is_next_ptr <= 1'b0;
			last_w1          <= 32'h0000_0000;
		end
		else if (take_desc)
		begin
			buf1_length      <= lnk.dec_len;
			buf1_skip        <= lnk.dec_skip;
			buf2_is_next_ptr <= chained;
			last_w1          <= desc_word1;
		end
	end

	// per-frame address action held for the whole frame;
	// later segments keep what the first one asked for
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			sa_insert      <= 1'b0;
			sa_replace     <= 1'b0;
			sa_addr_select <= 1'b0;
			crc_recompute  <= 1'b0;
		end
		else if (take_first)
		begin
			sa_insert      <= lnk.dec_insert;
			sa_replace     <= lnk.dec_replace;
			sa_addr_select <= lnk.dec_select;
			crc_recompute  <= lnk.dec_insert | lnk.dec_replace;
		end
	end

	////////////////////////////////////////////////////////////////////
	// status collection

	etd_state_e state;
	etd_state_e next_state;

	always_comb
	begin
		case (state)
			ETD_IDLE:
				next_state = take_first ? ETD_FRAME : ETD_IDLE;
			ETD_FRAME:
				next_state = frame_end ? ETD_IDLE : ETD_FRAME;
			default:
				next_state = ETD_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			state <= ETD_IDLE;
		else
			state <= next_state;
	end

	assign frame_open = (state == ETD_FRAME);

	// this cycle's events as word 0 bits
	logic [31:0] event_bits;

	always_comb
	begin
		event_bits = 32'h0000_0000;
		event_bits[W0_IP_HDR_FAULT]   = lnk.hdr_fault;
		event_bits[W0_JABBER_EXPIRED] = jabber_event & ~jabber_disable_bit;
		event_bits[W0_FLUSH_DROPPED]  = flush_event;
		event_bits[W0_PAYLOAD_FAULT]  = payload_fault_event;
		event_bits[W0_CARRIER_LOST]   = carrier_lost_event;
		event_bits[W0_NO_CARRIER]     = no_carrier_event;
		event_bits[W0_LATE_COLL]      = late_coll_event;
		event_bits[W0_EXCESS_COLL]    = excess_coll_event;
		event_bits[W0_EXCESS_DEFER]   = excess_defer_event;
		event_bits[W0_UNDERFLOW]      = underflow_event;
		// meaningless in full duplex, so kept out there
		event_bits[W0_DEFERRED]       = defer_event & half_duplex;
	end

	logic [31:0] accum;

	// a new frame clears the collection, but an event in that same
	// cycle still lands: set wins over clear
	wire [31:0] accum_base = take_first ? 32'h0000_0000 : accum;
	wire [31:0] next_accum = accum_base | event_bits;

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			accum <= 32'h0000_0000;
		else
			accum <= next_accum;
	end

	// summary covers every fault bit listed, including this cycle's
	function automatic logic summary(input logic [31:0] w);
		summary = w[W0_JABBER_EXPIRED] | w[W0_FLUSH_DROPPED]
			| w[W0_CARRIER_LOST] | w[W0_NO_CARRIER]
			| w[W0_LATE_COLL] | w[W0_EXCESS_COLL]
			| w[W0_EXCESS_DEFER] | w[W0_UNDERFLOW]
			| w[W0_IP_HDR_FAULT] | w[W0_PAYLOAD_FAULT];
	endfunction

	logic [31:0] final_word;

	always_comb
	begin
		final_word = next_accum;
		final_word[W0_COMBINED_FAULT] = summary(next_accum);
	end

	always_comb
	begin
		live_word = accum;
		live_word[W0_COMBINED_FAULT] = summary(accum);
	end

	////////////////////////////////////////////////////////////////////
	// write-back to the last descriptor

	// frame end outside a frame still writes back, so an abort that
	// races the first descriptor is never silently dropped
	wire do_wb = frame_end;

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			wb_valid <= 1'b0;
			wb_word0 <= 32'h0000_0000;
			last_wb  <= 32'h0000_0000;
		end
		else
		begin
			wb_valid <= do_wb;
			if (do_wb)
			begin
				wb_word0 <= final_word;
				last_wb  <= final_word;
			end
		end
	end

endmodule // eth_tx_descriptor_status_ctrl
`default_nettype wire

// ### testbench/etd_checker_sva.sv
// Purpose: assertions on the descriptor status ports
// Assumes: one clock, asynchronous active-low reset
// Notes:   sees only the top module's ports
`timescale 1ns/1ps
`default_nettype none
module etd_checker
(
	input wire logic        clock,
	input wire logic        resetn,
	input wire logic        desc_valid,
	input wire logic [31:0] desc_word0,
	input wire logic [31:0] desc_word1,
	input wire logic [12:0] buf1_length,
	input wire logic        buf1_skip,
	input wire logic        buf2_is_next_ptr,
	input wire logic        sa_insert,
	input wire logic        sa_replace,
	input wire logic        sa_addr_select,
	input wire logic        crc_recompute,
	input wire logic        flush_event,
	input wire logic        frame_end,
	input wire logic        wb_valid,
	input wire logic [31:0] wb_word0
);
default clocking @(posedge clock); endclocking
default disable iff (!resetn);
////////////////////////////////////////
wb_after_end_a: assert property (frame_end |=> wb_valid)
	else $error("no write-back after frame end");
wb_cause_a: assert property (wb_valid |-> $past(frame_end))
	else $error("write-back without frame end");
summary_or_a: assert property (wb_valid |-> wb_word0[15] ==
	(|{wb_word0[16], wb_word0[14:8], wb_word0[2:1]}))
	else $error("summary bit disagrees with fault bits");
flush_bit_a: assert property (frame_end && flush_event |=>
	wb_word0[13] && wb_word0[15])
	else $error("flush not reported");
buf_len_a: assert property (desc_valid |=>
	buf1_length == $past(desc_word1[12:0]) &&
	buf1_skip == ($past(desc_word1[12:0]) == 13'h0))
	else $error("buffer one length wrong");
chain_flag_a: assert property (desc_valid |=>
	buf2_is_next_ptr == $past(desc_word0[20]))
	else $error("chained flag wrong");
sa_code_a: assert property (
	desc_valid && desc_word0[28] |=>
	sa_insert == ($past(desc_word1[30:29]) == 2'h1) &&
	sa_replace == ($past(desc_word1[30:29]) == 2'h2) &&
	sa_addr_select == $past(desc_word1[31]))
	else $error("address action decode wrong");
sa_hold_a: assert property (
	desc_valid && !desc_word0[28] |=>
	$stable(sa_insert) && $stable(sa_replace) && $stable(sa_addr_select))
	else $error("address action changed off first segment");
crc_redo_a: assert property (
	crc_recompute == (sa_insert | sa_replace))
	else $error("crc recompute mismatch");
endmodule // etd_checker
bind eth_tx_descriptor_status_ctrl etd_checker u_etd_checker (.clock, .resetn,
	.desc_valid, .desc_word0, .desc_word1, .buf1_length, .buf1_skip,
	.buf2_is_next_ptr, .sa_insert, .sa_replace, .sa_addr_select,
	.crc_recompute, .flush_event, .frame_end, .wb_valid, .wb_word0);
`default_nettype wire

// ### testbench/etd_host_model.sv
// Purpose: host side that hands descriptors to the block
// Assumes: words presented for one cycle per descriptor
// Notes:   idle words are inverted so stale values never look valid
`timescale 1ns/1ps
`default_nettype none
module etd_host_model
(
	input  wire logic        clock,
	output logic             desc_valid,
	output logic      [31:0] desc_word0,
	output logic      [31:0] desc_word1
);
initial
begin
	desc_valid = 1'h0;
	desc_word0 = 32'h0;
	desc_word1 = 32'h0;
end
// frame bytes live elsewhere; insert means no address, replace means one
task automatic send(input logic fs, input logic [31:0] w1);
	@(posedge clock);
	desc_valid <= 1'h1;
	desc_word0 <= {3'h0, fs, 7'h0, w1[0], 20'h0};
	desc_word1 <= w1;
	@(posedge clock);
	desc_valid <= 1'h0;
	desc_word0 <= ~desc_word0;
	desc_word1 <= ~w1;
endtask
endmodule // etd_host_model
`default_nettype wire

// ### testbench/eth_tx_descriptor_status_ctrl_tb_top.sv
// Purpose: directed bench for descriptor status and word 1 decode
// Assumes: 40 MHz clock, reset held four cycles
// Notes:   all event inputs pulse for the frame-end cycle only
`timescale 1ns/1ps
`default_nettype none
module eth_tx_descriptor_status_ctrl_tb_top;
logic        clock, resetn, reg_write, reg_read, desc_valid, hdr_valid;
logic        frame_end, buf1_skip, buf2_is_next_ptr, sa_insert, sa_replace;
logic        sa_addr_select, crc_recompute, wb_valid;
logic [7:0]  reg_addr, hdr_bytes;
logic [31:0] reg_wdata, reg_rdata, desc_word0, desc_word1, wb_word0;
logic [12:0] buf1_length;
logic [15:0] hdr_length_type;
logic [3:0]  hdr_version, hdr_ihl;
logic [9:0]  ev;
int          errors, checked, cycles;
int          pos [10] = '{14, 13, 11, 10, 9, 8, 2, 1, 12, 0};
eth_tx_descriptor_status_ctrl u_eth_tx_descriptor_status_ctrl (.clock,
	.resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
	.desc_valid, .desc_word0, .desc_word1, .buf1_length, .buf1_skip,
	.buf2_is_next_ptr, .sa_insert, .sa_replace, .sa_addr_select,
	.crc_recompute, .hdr_valid, .hdr_length_type, .hdr_version, .hdr_ihl,
	.hdr_bytes, .jabber_event(ev[0]), .flush_event(ev[1]),
	.carrier_lost_event(ev[2]), .no_carrier_event(ev[3]),
	.late_coll_event(ev[4]), .excess_coll_event(ev[5]),
	.excess_defer_event(ev[6]), .underflow_event(ev[7]),
	.payload_fault_event(ev[8]), .defer_event(ev[9]), .frame_end,
	.wb_valid, .wb_word0);
etd_host_model u_etd_host_model (.clock, .desc_valid, .desc_word0,
	.desc_word1);
////////////////////////////////////////
task automatic finish_test();
	$display("errors %0d checked %0d", errors, checked);
	if (errors == 0 && checked > 0)
		$display("bench passed");
	else
		$display("bench failed");
	$finish;
endtask
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	checked++;
	if (got !== exp)
	begin
		errors++;
		$display("unexpected at %0t: got %h want %h", $time, got, exp);
	end
endtask
task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
	@(posedge clock);
	reg_write <= 1'h1;
	reg_addr <= a;
	reg_wdata <= d;
	@(posedge clock);
	reg_write <= 1'h0;
endtask
task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
	@(posedge clock);
	reg_read <= 1'h1;
	reg_addr <= a;
	@(posedge clock);
	reg_read <= 1'h0;
	#1;
	chk(reg_rdata, exp);
endtask
// sa packs insert, replace, select, crc
task automatic desc(input logic fs, input logic [31:0] w1,
	input logic [3:0] sa);
	u_etd_host_model.send(fs, w1);
	#1;
	chk({19'h0, buf1_length}, {19'h0, w1[12:0]});
	chk({31'h0, buf1_skip}, {31'h0, w1[12:0] == 13'h0});
	chk({31'h0, buf2_is_next_ptr}, {31'h0, w1[0]});
	chk({28'h0, sa_insert, sa_replace, sa_addr_select, crc_recompute},
		{28'h0, sa});
endtask
task automatic frame(input logic [9:0] e, input logic [15:0] lt,
	input logic [3:0] v, input logic [3:0] ihl, input logic [7:0] nb,
	input logic [31:0] exp);
	u_etd_host_model.send(1'h1, 32'h40);
	@(posedge clock);
	ev <= e;
	hdr_valid <= 1'h1;
	hdr_length_type <= lt;
	hdr_version <= v;
	hdr_ihl <= ihl;
	hdr_bytes <= nb;
	frame_end <= 1'h1;
	@(posedge clock);
	ev <= 10'h0;
	hdr_valid <= 1'h0;
	frame_end <= 1'h0;
	#1;
	chk({31'h0, wb_valid}, 32'h1);
	chk(wb_word0, exp);
endtask
////////////////////////////////////////
initial
begin
	clock = 1'h0;
	forever #12.5 clock = ~clock;
end
always @(posedge clock)
begin
	cycles++;
	if (cycles == 3000)
	begin
		errors++;
		finish_test();
	end
end
initial
begin
	{resetn, reg_write, reg_read, hdr_valid, frame_end} = 5'h0;
	{reg_addr, reg_wdata, hdr_bytes, hdr_length_type} = 64'h0;
	{hdr_version, hdr_ihl, ev} = 18'h0;
	repeat (4) @(posedge clock);
	resetn <= 1'h1;
	reg_rd(8'h00, 32'h0);
	reg_wr(8'h04, 32'hFFFFFFFF);
	reg_rd(8'h04, 32'h0);
	reg_rd(8'h40, 32'h0);
	desc(1'h1, 32'h00000000, 4'h0);
	desc(1'h1, 32'hBFFFFFFF, 4'hB);
	desc(1'h1, 32'h40000041, 4'h5);
	desc(1'h0, 32'h20000002, 4'h5);
	desc(1'h1, 32'h60000003, 4'h0);
	reg_wr(8'h00, 32'h2);
	for (int i = 0; i < 10; i++)
		frame(10'h1 << i, 16'h0, 4'h0, 4'h0, 8'h0, (32'h1 << pos[i]) |
			(pos[i] != 0 ? 32'h8000 : 32'h0));
	reg_wr(8'h00, 32'h1);
	reg_rd(8'h00, 32'h1);
	desc(1'h1, 32'h00000040, 4'h0);
	reg_rd(8'h00, 32'h5);
	frame(10'h201, 16'h0, 4'h0, 4'h0, 8'h0, 32'h0);
	frame(10'h0, 16'h0800, 4'h4, 4'h5, 8'h14, 32'h0);
	frame(10'h0, 16'h0800, 4'h4, 4'h5, 8'h18, 32'h18000);
	frame(10'h0, 16'h0800, 4'h4, 4'h4, 8'h10, 32'h18000);
	frame(10'h0, 16'h86DD, 4'h6, 4'h0, 8'h28, 32'h0);
	frame(10'h0, 16'h86DD, 4'h6, 4'h0, 8'h27, 32'h18000);
	frame(10'h0, 16'h0800, 4'h6, 4'h5, 8'h14, 32'h18000);
	reg_rd(8'h04, 32'h18000);
	reg_rd(8'h08, 32'h18000);
	reg_rd(8'h0C, 32'h40);
	reg_rd(8'h00, 32'h1);
	finish_test();
end
endmodule // eth_tx_descriptor_status_ctrl_tb_top
`default_nettype wire
